// ---- rtl/btc_bank_two.sv ----
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
module btc_bank_two import btc_pkg::*; (
	input wire logic clk_i, // Core clock, 40 MHz.
	input wire logic rst_i, // Power-on or brown-out reset.
	input wire logic warm_rst_i, // Any other reset, synchronous.
	input wire logic cyc_i, // Wishbone cycle.
	input wire logic stb_i, // Wishbone strobe.
	input wire logic we_i, // Wishbone write.
	input wire logic [13:0] adr_i, // Wishbone byte address.
	input wire logic [3:0] sel_i, // Wishbone byte selects.
	input wire logic [31:0] dat_i, // Wishbone write data.
	output logic [31:0] dat_o, // Wishbone read data.
	output logic ack_o, // Wishbone acknowledge.
	output btc_mem_req_t mem_req_o, // Indirect memory request.
	output logic mem_cyc_o, // Indirect memory cycle.
	output logic mem_stb_o, // Indirect memory strobe.
	input wire logic mem_ack_i, // Indirect memory acknowledge.
	input wire logic [7:0] mem_dat_i, // Indirect memory read data.
	output logic [7:0] pcl_o, // Program counter low byte.
	output logic [4:0] status_o, // Condition flags.
	output logic [15:0] ptr0_o, // Pointer zero pair.
	output logic [15:0] ptr1_o, // Pointer one pair.
	output logic [4:0] bsel_o, // Bank selector.
	output logic [7:0] wacc_o, // Working accumulator.
	output logic [6:0] pcub_o, // Program counter upper buffer.
	output logic [7:0] ictl_o, // Interrupt control.
	output logic [7:0] lat_a_o, // Port A latch.
	output logic [7:0] lat_b_o, // Port B latch.
	output logic [7:0] lat_c_o, // Port C latch.
	output logic [7:0] lat_d_o, // Port D latch.
	output logic [2:0] lat_e_o // Port E latch.
);

	logic ack_reg;
	logic ack_next;
	logic [7:0] rd_reg;
	logic [7:0] rd_next;

	wire req;
	wire [11:0] idx;
	wire [6:0] off;
	wire core_hit;
	wire bank_hit;
	wire hit_win0;
	wire hit_win1;
	wire hit_pcl;
	wire hit_stat;
	wire hit_p0l;
	wire hit_p0h;
	wire hit_p1l;
	wire hit_p1h;
	wire hit_bsel;
	wire hit_wacc;
	wire hit_pcub;
	wire hit_ictl;
	wire hit_port_a_output_latch;
	wire hit_port_b_output_latch;
	wire hit_port_c_output_latch;
	wire hit_port_d_output_latch;
	wire hit_late;
	wire win_req;
	wire wr_ok;
	wire [7:0] wbyte;
	wire [7:0] q_pcl;
	wire [7:0] q_stat;
	wire [7:0] q_p0l;
	wire [7:0] q_p0h;
	wire [7:0] q_p1l;
	wire [7:0] q_p1h;
	wire [7:0] q_bsel;
	wire [7:0] q_wacc;
	wire [7:0] q_pcub;
	wire [7:0] q_ictl;
	wire [7:0] q_port_a_output_latch;
	wire [7:0] q_port_b_output_latch;
	wire [7:0] q_port_c_output_latch;
	wire [7:0] q_port_d_output_latch;
	wire [7:0] q_late;
	wire [7:0] rd_mux;
	wire [15:0] win_ptr;
	wire br_start;
	wire br_idle;
	wire br_done;
	wire [7:0] br_rdata;
	wire bridge_rst;

	// Address decode; bits 1:0 of the byte address are ignored.
	assign req = cyc_i & stb_i;
	assign idx = adr_i[13:2];
	assign off = idx[6:0];
	assign wbyte = dat_i[7:0];

	// Core registers ignore the bank number so all banks share one copy.
	assign core_hit = (off <= CORE_TOP);
	assign bank_hit = (idx[11:7] == BANK_TWO);

	// Core register selects.
	assign hit_win0 = core_hit & (off == IDX_WIN0[6:0]);
	assign hit_win1 = core_hit & (off == IDX_WIN1[6:0]);
	assign hit_pcl = core_hit & (off == IDX_PCL[6:0]);
	assign hit_stat = core_hit & (off == IDX_STAT[6:0]);
	assign hit_p0l = core_hit & (off == IDX_P0L[6:0]);
	assign hit_p0h = core_hit & (off == IDX_P0H[6:0]);
	assign hit_p1l = core_hit & (off == IDX_P1L[6:0]);
	assign hit_p1h = core_hit & (off == IDX_P1H[6:0]);
	assign hit_bsel = core_hit & (off == IDX_BSEL[6:0]);
	assign hit_wacc = core_hit & (off == IDX_WACC[6:0]);
	assign hit_pcub = core_hit & (off == IDX_PCUB[6:0]);
	assign hit_ictl = core_hit & (off == IDX_ICTL[6:0]);

	// Port latches exist only in this bank.
	assign hit_port_a_output_latch = bank_hit & (off == IDX_PORT_A_OUTPUT_LATCH[6:0]);
	assign hit_port_b_output_latch = bank_hit & (off == IDX_PORT_B_OUTPUT_LATCH[6:0]);
	assign hit_port_c_output_latch = bank_hit & (off == IDX_PORT_C_OUTPUT_LATCH[6:0]);
	assign hit_port_d_output_latch = bank_hit & (off == IDX_PORT_D_OUTPUT_LATCH[6:0]);
	assign hit_late = bank_hit & (off == IDX_LATE[6:0]);

	// A window write with the low lane off has nothing to carry, so it
	// is answered directly instead of touching memory.
	assign win_req = req & (hit_win0 | hit_win1) & (~we_i | sel_i[0]);
	assign win_ptr = hit_win1 ? {q_p1h, q_p1l} : {q_p0h, q_p0l};
	assign br_start = win_req & ~ack_reg & br_idle;
	assign bridge_rst = rst_i | warm_rst_i;

	// Writes land on the edge where the master sees acknowledge.
	assign wr_ok = req & we_i & sel_i[0] & ack_reg & ~win_req;

	// Direct accesses answer one cycle after the request; windows wait for memory.
	assign ack_next = (req & ~ack_reg & ~win_req) | br_done;
	assign rd_next = br_done ? br_rdata : rd_mux;

	// Read selection; unmatched addresses and unused bits fall to zero.
	assign rd_mux = ({8{hit_pcl}} & q_pcl)
		| ({8{hit_stat}} & q_stat)
		| ({8{hit_p0l}} & q_p0l)
		| ({8{hit_p0h}} & q_p0h)
		| ({8{hit_p1l}} & q_p1l)
		| ({8{hit_p1h}} & q_p1h)
		| ({8{hit_bsel}} & q_bsel)
		| ({8{hit_wacc}} & q_wacc)
		| ({8{hit_pcub}} & q_pcub)
		| ({8{hit_ictl}} & q_ictl)
		| ({8{hit_port_a_output_latch}} & q_port_a_output_latch)
		| ({8{hit_port_b_output_latch}} & q_port_b_output_latch)
		| ({8{hit_port_c_output_latch}} & q_port_c_output_latch)
		| ({8{hit_port_d_output_latch}} & q_port_d_output_latch)
		| ({8{hit_late}} & (q_late | ONE_LATE));

	// Acknowledge and read data are registered so the bus sees clean levels.
	always_ff @(posedge clk_i) begin
		if (rst_i || warm_rst_i) begin
			ack_reg <= 1'b0;
			rd_reg <= 8'h00;
		end else begin
			ack_reg <= ack_next;
			if (ack_next) begin
				rd_reg <= rd_next;
			end
		end
	end

	assign ack_o = ack_reg;
	assign dat_o = {24'h000000, rd_reg};

	// Indirect window engine toward data memory.
	btc_ind_bridge u_bridge (
		.clk_i(clk_i),
		.rst_i(bridge_rst),
		.start_i(br_start),
		.we_i(we_i),
		.ptr_i(win_ptr),
		.wdata_i(wbyte),
		.idle_o(br_idle),
		.done_o(br_done),
		.rdata_o(br_rdata),
		.mem_req_o(mem_req_o),
		.mem_cyc_o(mem_cyc_o),
		.mem_stb_o(mem_stb_o),
		.mem_ack_i(mem_ack_i),
		.mem_dat_i(mem_dat_i)
	);

	// Program counter low byte, cleared on every reset.
	btc_byte_reg #(.WR_MASK(WM_FULL), .POR_VAL(POR_ZERO), .WARM_CLR(1'b1)) u_pcl (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.warm_rst_i(warm_rst_i),
		.wr_i(wr_ok & hit_pcl),
		.wdata_i(wbyte),
		.q_o(q_pcl)
	);

	// Condition flags; the two top flags only report and ignore writes.
	btc_byte_reg #(.WR_MASK(WM_STAT), .POR_VAL(POR_STAT), .WARM_CLR(1'b0)) u_stat (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.warm_rst_i(warm_rst_i),
		.wr_i(wr_ok & hit_stat),
		.wdata_i(wbyte),
		.q_o(q_stat)
	);

	// Pointer zero low survives a warm reset.
	btc_byte_reg #(.WR_MASK(WM_FULL), .POR_VAL(POR_ZERO), .WARM_CLR(1'b0)) u_p0l (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.warm_rst_i(warm_rst_i),
		.wr_i(wr_ok & hit_p0l),
		.wdata_i(wbyte),
		.q_o(q_p0l)
	);

	// Pointer zero high clears on any reset.
	btc_byte_reg #(.WR_MASK(WM_FULL), .POR_VAL(POR_ZERO), .WARM_CLR(1'b1)) u_p0h (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.warm_rst_i(warm_rst_i),
		.wr_i(wr_ok & hit_p0h),
		.wdata_i(wbyte),
		.q_o(q_p0h)
	);

	// Pointer one low survives a warm reset.
	btc_byte_reg #(.WR_MASK(WM_FULL), .POR_VAL(POR_ZERO), .WARM_CLR(1'b0)) u_p1l (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.warm_rst_i(warm_rst_i),
		.wr_i(wr_ok & hit_p1l),
		.wdata_i(wbyte),
		.q_o(q_p1l)
	);

	// Pointer one high clears on any reset.
	btc_byte_reg #(.WR_MASK(WM_FULL), .POR_VAL(POR_ZERO), .WARM_CLR(1'b1)) u_p1h (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.warm_rst_i(warm_rst_i),
		.wr_i(wr_ok & hit_p1h),
		.wdata_i(wbyte),
		.q_o(q_p1h)
	);

	// Bank selector holds five bits.
	btc_byte_reg #(.WR_MASK(WM_BSEL), .POR_VAL(POR_ZERO), .WARM_CLR(1'b1)) u_bsel (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.warm_rst_i(warm_rst_i),
		.wr_i(wr_ok & hit_bsel),
		.wdata_i(wbyte),
		.q_o(q_bsel)
	);

	// Working accumulator keeps its value on a warm reset.
	btc_byte_reg #(.WR_MASK(WM_FULL), .POR_VAL(POR_ZERO), .WARM_CLR(1'b0)) u_wacc (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.warm_rst_i(warm_rst_i),
		.wr_i(wr_ok & hit_wacc),
		.wdata_i(wbyte),
		.q_o(q_wacc)
	);

	// Upper program counter buffer: seven bits, top bit stays zero.
	btc_byte_reg #(.WR_MASK(WM_PCUB), .POR_VAL(POR_ZERO), .WARM_CLR(1'b1)) u_pcub (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.warm_rst_i(warm_rst_i),
		.wr_i(wr_ok & hit_pcub),
		.wdata_i(wbyte),
		.q_o(q_pcub)
	);

	// Interrupt control clears on any reset.
	btc_byte_reg #(.WR_MASK(WM_FULL), .POR_VAL(POR_ZERO), .WARM_CLR(1'b1)) u_ictl (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.warm_rst_i(warm_rst_i),
		.wr_i(wr_ok & hit_ictl),
		.wdata_i(wbyte),
		.q_o(q_ictl)
	);

	// Port latches keep their contents on a warm reset.
	btc_byte_reg #(.WR_MASK(WM_FULL), .POR_VAL(POR_ZERO), .WARM_CLR(1'b0)) u_port_a_output_latch (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.warm_rst_i(warm_rst_i),
		.wr_i(wr_ok & hit_port_a_output_latch),
		.wdata_i(wbyte),
		.q_o(q_port_a_output_latch)
	);

	btc_byte_reg #(.WR_MASK(WM_FULL), .POR_VAL(POR_ZERO), .WARM_CLR(1'b0)) u_port_b_output_latch (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.warm_rst_i(warm_rst_i),
		.wr_i(wr_ok & hit_port_b_output_latch),
		.wdata_i(wbyte),
		.q_o(q_port_b_output_latch)
	);

	btc_byte_reg #(.WR_MASK(WM_FULL), .POR_VAL(POR_ZERO), .WARM_CLR(1'b0)) u_port_c_output_latch (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.warm_rst_i(warm_rst_i),
		.wr_i(wr_ok & hit_port_c_output_latch),
		.wdata_i(wbyte),
		.q_o(q_port_c_output_latch)
	);

	btc_byte_reg #(.WR_MASK(WM_FULL), .POR_VAL(POR_ZERO), .WARM_CLR(1'b0)) u_port_d_output_latch (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.warm_rst_i(warm_rst_i),
		.wr_i(wr_ok & hit_port_d_output_latch),
		.wdata_i(wbyte),
		.q_o(q_port_d_output_latch)
	);

	// Port E has three latch bits; writes to the rest are dropped.
	btc_byte_reg #(.WR_MASK(WM_LATE), .POR_VAL(POR_ZERO), .WARM_CLR(1'b0)) u_late (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.warm_rst_i(warm_rst_i),
		.wr_i(wr_ok & hit_late),
		.wdata_i(wbyte),
		.q_o(q_late)
	);

	// Core-facing copies of the stored state.
	assign pcl_o = q_pcl;
	assign status_o = q_stat[4:0];
	assign ptr0_o = {q_p0h, q_p0l};
	assign ptr1_o = {q_p1h, q_p1l};
	assign bsel_o = q_bsel[4:0];
	assign wacc_o = q_wacc;
	assign pcub_o = q_pcub[6:0];
	assign ictl_o = q_ictl;
	assign lat_a_o = q_port_a_output_latch;
	assign lat_b_o = q_port_b_output_latch;
	assign lat_c_o = q_port_c_output_latch;
	assign lat_d_o = q_port_d_output_latch;
	assign lat_e_o = q_late[2:0];

endmodule

// ---- rtl/btc_pkg.sv ----
package btc_pkg;

	// Wishbone byte address carries the data-memory index in bits 13:2.
	localparam int ADR_W = 14;
	localparam int IDX_W = 12;
	localparam int PTR_W = 16;

	// Data-memory indices of the bank; byte address is four times the index.
	localparam logic [11:0] IDX_WIN0 = 12'h100;
	localparam logic [11:0] IDX_WIN1 = 12'h101;
	localparam logic [11:0] IDX_PCL = 12'h102;
	localparam logic [11:0] IDX_STAT = 12'h103;
	localparam logic [11:0] IDX_P0L = 12'h104;
	localparam logic [11:0] IDX_P0H = 12'h105;
	localparam logic [11:0] IDX_P1L = 12'h106;
	localparam logic [11:0] IDX_P1H = 12'h107;
	localparam logic [11:0] IDX_BSEL = 12'h108;
	localparam logic [11:0] IDX_WACC = 12'h109;
	localparam logic [11:0] IDX_PCUB = 12'h10A;
	localparam logic [11:0] IDX_ICTL = 12'h10B;
	localparam logic [11:0] IDX_PORT_A_OUTPUT_LATCH = 12'h10C;
	localparam logic [11:0] IDX_PORT_B_OUTPUT_LATCH = 12'h10D;
	localparam logic [11:0] IDX_PORT_C_OUTPUT_LATCH = 12'h10E;
	localparam logic [11:0] IDX_PORT_D_OUTPUT_LATCH = 12'h10F;
	localparam logic [11:0] IDX_LATE = 12'h110;

	// Mirrored core registers occupy the low offsets of every bank.
	localparam logic [6:0] CORE_TOP = 7'h0B;
	localparam logic [4:0] BANK_TWO = 5'h02;

	// Software-writable bits of each register; clear bits keep their reset value.
	localparam logic [7:0] WM_FULL = 8'hFF;
	localparam logic [7:0] WM_STAT = 8'h07;
	localparam logic [7:0] WM_BSEL = 8'h1F;
	localparam logic [7:0] WM_PCUB = 8'h7F;
	localparam logic [7:0] WM_LATE = 8'h07;

	// Bits that read as one and ignore writes.
	localparam logic [7:0] ONE_LATE = 8'h00;

	// Power-on and brown-out values.
	localparam logic [7:0] POR_ZERO = 8'h00;
	localparam logic [7:0] POR_STAT = 8'h18;

	// Request carried to data memory by an indirect window access.
	typedef struct packed {
		logic [15:0] adr;
		logic we;
		logic [7:0] dat;
	} btc_mem_req_t;

	typedef enum {BR_IDLE, BR_WAIT, BR_DONE} btc_br_state_t;

endpackage

// ---- rtl/btc_byte_reg.sv ----
`timescale 1ns/1ps
module btc_byte_reg import btc_pkg::*; #(
	parameter logic [7:0] WR_MASK = 8'hFF,
	parameter logic [7:0] POR_VAL = 8'h00,
	parameter bit WARM_CLR = 1'b0
) (
	input wire logic clk_i, // Core clock.
	input wire logic rst_i, // Power-on or brown-out reset.
	input wire logic warm_rst_i, // Any other reset.
	input wire logic wr_i, // Write strobe.
	input wire logic [7:0] wdata_i, // Write data.
	output logic [7:0] q_o // Stored value.
);

	logic [7:0] q_reg;
	logic [7:0] q_next;

	// Only masked bits take write data, so unimplemented bits stay at reset.
	assign q_next = (q_reg & ~WR_MASK) | (wdata_i & WR_MASK);
	assign q_o = q_reg;

	// A warm reset clears only registers that are cleared on every reset.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_reg <= POR_VAL;
		end else if (warm_rst_i && WARM_CLR) begin
			q_reg <= POR_VAL;
		end else if (wr_i) begin
			q_reg <= q_next;
		end
	end

endmodule

// ---- rtl/btc_ind_bridge.sv ----
`timescale 1ns/1ps
module btc_ind_bridge import btc_pkg::*; (
	input wire logic clk_i, // Core clock.
	input wire logic rst_i, // Synchronous reset, any source.
	input wire logic start_i, // Begin one indirect access.
	input wire logic we_i, // Access is a write.
	input wire logic [15:0] ptr_i, // Pointer pair value.
	input wire logic [7:0] wdata_i, // Byte to write.
	output logic idle_o, // Ready to start.
	output logic done_o, // One-cycle completion pulse.
	output logic [7:0] rdata_o, // Byte read from memory.
	output btc_mem_req_t mem_req_o, // Address, direction, data.
	output logic mem_cyc_o, // Memory cycle.
	output logic mem_stb_o, // Memory strobe.
	input wire logic mem_ack_i, // Memory acknowledge.
	input wire logic [7:0] mem_dat_i // Memory read data.
);

	btc_br_state_t state_reg;
	btc_br_state_t state_next;
	btc_mem_req_t req_reg;
	logic [7:0] rdata_reg;

	// The window holds nothing; the pointer is latched so a change mid-cycle is harmless.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			BR_IDLE: begin
				if (start_i) begin
					state_next = BR_WAIT;
				end
			end
			BR_WAIT: begin
				if (mem_ack_i) begin
					state_next = BR_DONE;
				end
			end
			BR_DONE: begin
				state_next = BR_IDLE;
			end
			default: begin
				state_next = BR_IDLE;
			end
		endcase
	end

	// State, request and captured data.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= BR_IDLE;
			req_reg <= '0;
			rdata_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			if (state_reg == BR_IDLE && start_i) begin
				req_reg <= '{adr: ptr_i, we: we_i, dat: wdata_i};
			end
			if (state_reg == BR_WAIT && mem_ack_i) begin
				rdata_reg <= mem_dat_i;
			end
		end
	end

	assign idle_o = (state_reg == BR_IDLE);
	assign done_o = (state_reg == BR_DONE);
	assign rdata_o = rdata_reg;
	assign mem_req_o = req_reg;
	assign mem_cyc_o = (state_reg == BR_WAIT);
	assign mem_stb_o = (state_reg == BR_WAIT);

endmodule

// ---- testbench/btc_bank_two_properties.sv ----
`timescale 1ns/1ps
module btc_bank_two_properties import btc_pkg::*; (
	input wire logic clk_i, // Core clock.
	input wire logic rst_i, // Power-on reset.
	input wire logic warm_rst_i, // Other reset.
	input wire logic we_i, // Bus write.
	input wire logic [13:0] adr_i, // Bus address.
	input wire logic [31:0] dat_o, // Bus read data.
	input wire logic ack_o, // Bus acknowledge.
	input wire btc_mem_req_t mem_req_o, // Indirect request.
	input wire logic mem_stb_o, // Indirect strobe.
	input wire logic mem_ack_i, // Memory answer.
	input wire logic [15:0] ptr0_o, // Pointer zero.
	input wire logic [15:0] ptr1_o, // Pointer one.
	input wire logic [6:0] pcub_o, // Upper buffer.
	input wire logic [7:0] wacc_o, // Accumulator.
	input wire logic [7:0] lat_a_o // Port A latch.
);
	// Everything here runs on the core clock; power-on reset silences all checks.
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_win0;
		mem_stb_o && adr_i[8:2] == 7'h00 |-> mem_req_o.adr == ptr0_o;
	endproperty
	property p_win1;
		mem_stb_o && adr_i[8:2] == 7'h01 |-> mem_req_o.adr == ptr1_o;
	endproperty
	// A warm reset aborts the bridge, so the answer latency is only owed without one.
	property p_win_ack;
		disable iff (rst_i || warm_rst_i) mem_stb_o && mem_ack_i |-> ##2 ack_o;
	endproperty
	property p_mirror;
		ack_o && !we_i && adr_i[8:2] == 7'h09 |-> dat_o == {24'h0, wacc_o};
	endproperty
	property p_pcub_rd;
		ack_o && !we_i && adr_i[8:2] == 7'h0A |-> dat_o == {25'h0, pcub_o};
	endproperty
	property p_pcub_warm;
		warm_rst_i |=> pcub_o == 7'h00;
	endproperty
	property p_p0h_warm;
		warm_rst_i |=> ptr0_o[15:8] == 8'h00;
	endproperty
	property p_p0l_keep;
		warm_rst_i && !ack_o |=> $stable(ptr0_o[7:0]);
	endproperty
	property p_p1h_warm;
		warm_rst_i |=> ptr1_o[15:8] == 8'h00;
	endproperty
	property p_unmapped;
		ack_o && !we_i && adr_i[13:2] == 12'h111 |-> dat_o == 32'h0;
	endproperty
	property p_latch;
		ack_o && !we_i && adr_i[13:2] == IDX_PORT_A_OUTPUT_LATCH |-> dat_o == {24'h0, lat_a_o};
	endproperty
	a_win0: assert property (p_win0) else $error("window zero address wrong");
	a_win1: assert property (p_win1) else $error("window one address wrong");
	a_win_ack: assert property (p_win_ack) else $error("window ack late");
	a_mirror: assert property (p_mirror) else $error("mirrored read wrong");
	a_pcub_rd: assert property (p_pcub_rd) else $error("upper buffer read wrong");
	a_pcub_warm: assert property (p_pcub_warm) else $error("upper buffer kept");
	a_p0h_warm: assert property (p_p0h_warm) else $error("pointer zero high kept");
	a_p0l_keep: assert property (p_p0l_keep) else $error("pointer zero low lost");
	a_p1h_warm: assert property (p_p1h_warm) else $error("pointer one high kept");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
	a_latch: assert property (p_latch) else $error("latch read wrong");
	c_mem: cover property (mem_stb_o && mem_ack_i);
	c_warm: cover property (warm_rst_i);
	c_read: cover property (ack_o && !we_i);
endmodule

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
	import btc_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic warm_rst_i = 1'b0;
	logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, mem_ack_i = 1'b0, ack_o, mem_cyc_o, mem_stb_o;
	logic [13:0] adr_i = 14'h0;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0, dat_o, rd;
	logic [7:0] mem_dat_i = 8'h00, mem_byte = 8'h00;
	logic [7:0] pcl_o, wacc_o, ictl_o, lat_a_o, lat_b_o, lat_c_o, lat_d_o;
	logic [4:0] status_o, bsel_o;
	logic [15:0] ptr0_o, ptr1_o;
	logic [6:0] pcub_o;
	logic [2:0] lat_e_o;
	btc_mem_req_t mem_req_o, seen_req;
	int fail_count = 0, cmp_count = 0, cycles = 0, mem_wait = 0, mem_cnt = 0;
	logic [3:0] sel_use = 4'h1;

	btc_bank_two btc_bank_two_i (.clk_i, .rst_i, .warm_rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
		.sel_i, .dat_i, .dat_o, .ack_o, .mem_req_o, .mem_cyc_o, .mem_stb_o, .mem_ack_i,
		.mem_dat_i, .pcl_o, .status_o, .ptr0_o, .ptr1_o, .bsel_o, .wacc_o, .pcub_o, .ictl_o,
		.lat_a_o, .lat_b_o, .lat_c_o, .lat_d_o, .lat_e_o);

	// Free-running core clock.
	initial begin
		forever #12.5 clk_i = ~clk_i;
	end

	// Memory stand-in; its data lines wander while it is not answering.
	always @(posedge clk_i) begin
		// Answering only a full cycle and strobe means a dead cycle line makes window accesses time out.
		if (mem_cyc_o && mem_stb_o && !mem_ack_i && mem_cnt >= mem_wait) begin
			mem_ack_i <= 1'b1;
			mem_dat_i <= mem_byte;
			seen_req <= mem_req_o;
			mem_cnt <= 0;
		end else begin
			mem_ack_i <= 1'b0;
			mem_dat_i <= ~mem_dat_i;
			mem_cnt <= mem_stb_o ? mem_cnt + 1 : 0;
		end
	end

	// Cut a hang short well beyond the few hundred bus cycles the tests need.
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One classic cycle; the request holds until ack is sampled, then one idle cycle.
	task automatic wb(input logic w, input logic [11:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= {idx, 2'b00};
		sel_i <= sel_use;
		dat_i <= {24'h0, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 200);
		chk("ack_o", 32'h1, {31'h0, ack_o});
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic rdc(input logic [11:0] idx, input logic [7:0] exp);
		wb(1'b0, idx, 8'h00);
		chk($sformatf("read %h", idx), {24'h0, exp}, rd);
	endtask

	function automatic logic [7:0] wmask(input int i);
		case (i[11:0])
			IDX_STAT: return POR_STAT | WM_STAT;
			IDX_BSEL: return WM_BSEL;
			IDX_PCUB: return WM_PCUB;
			IDX_LATE: return WM_LATE;
			IDX_WIN0 + 12'h011: return 8'h00;
			default: return WM_FULL;
		endcase
	endfunction

	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		for (int i = 'h102; i <= 'h111; i++) rdc(i[11:0], i == 'h103 ? 8'h18 : 8'h00);
		$display("reset values done");
		// All ones written to every index but the windows; only implemented bits may stick.
		for (int i = 'h102; i <= 'h111; i++) wb(1'b1, i[11:0], 8'hFF);
		for (int i = 'h102; i <= 'h111; i++) rdc(i[11:0], wmask(i));
		chk("upper buffer port", 32'h7F, {25'h0, pcub_o});
		chk("port e latch", 32'h7, {29'h0, lat_e_o});
		chk("core ports", {8'hFF, 3'h0, 5'h1F, 3'h0, 5'h1F, 8'hFF},
			{pcl_o, 3'h0, status_o, 3'h0, bsel_o, wacc_o});
		chk("latch ports", 32'hFFFF_FFFF, {ictl_o, lat_b_o, lat_c_o, lat_d_o});
		$display("write masks done");
		// Core registers reached from other banks; latch offsets elsewhere are empty.
		wb(1'b1, 12'h289, 8'h5A);
		rdc(12'h009, 8'h5A);
		rdc(12'h389, 8'h5A);
		rdc(12'h30C, 8'h00);
		$display("mirroring done");
		// Window accesses, the second through a mirror with a slow memory.
		wb(1'b1, IDX_P0H, 8'h12);
		wb(1'b1, IDX_P0L, 8'h34);
		wb(1'b1, 12'h207, 8'h0A);
		wb(1'b1, IDX_P1L, 8'h5C);
		wb(1'b1, IDX_WIN0, 8'hC3);
		chk("window zero request", {7'h0, 16'h1234, 1'b1, 8'hC3}, {7'h0, seen_req});
		mem_wait = 5;
		mem_byte = 8'h96;
		rdc(12'h181, 8'h96);
		chk("window one request", {15'h0, 16'h0A5C, 1'b0}, {15'h0, seen_req.adr, seen_req.we});
		// Writes with the low lane off are acknowledged but change nothing.
		sel_use = 4'h0;
		wb(1'b1, IDX_WACC, 8'h00);
		wb(1'b1, IDX_WIN0, 8'h11);
		sel_use = 4'h1;
		chk("dropped window", {7'h0, 16'h0A5C, 1'b0, 8'h00}, {7'h0, seen_req});
		$display("windows done");
		// Warm reset: some registers clear, the rest keep their contents.
		warm_rst_i <= 1'b1;
		@(posedge clk_i);
		warm_rst_i <= 1'b0;
		@(posedge clk_i);
		chk("pointer ports", 32'h0034_005C, {ptr0_o, ptr1_o});
		rdc(IDX_PCL, 8'h00);
		rdc(IDX_STAT, 8'h1F);
		rdc(IDX_P0L, 8'h34);
		rdc(IDX_P0H, 8'h00);
		rdc(IDX_P1H, 8'h00);
		rdc(IDX_BSEL, 8'h00);
		rdc(IDX_WACC, 8'h5A);
		rdc(IDX_PCUB, 8'h00);
		rdc(IDX_ICTL, 8'h00);
		rdc(IDX_PORT_A_OUTPUT_LATCH, 8'hFF);
		$display("warm reset done");
		// Power-on reset does clear the low pointer.
		rst_i <= 1'b1;
		@(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rdc(IDX_P0L, 8'h00);
		rdc(IDX_PORT_A_OUTPUT_LATCH, 8'h00);
		$display("power-on reset done");
		finish_test();
	end
endmodule

bind btc_bank_two btc_bank_two_properties btc_bank_two_properties_i (.clk_i(clk_i),
	.rst_i(rst_i), .warm_rst_i(warm_rst_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o),
	.ack_o(ack_o), .mem_req_o(mem_req_o), .mem_stb_o(mem_stb_o), .mem_ack_i(mem_ack_i),
	.ptr0_o(ptr0_o), .ptr1_o(ptr1_o), .pcub_o(pcub_o), .wacc_o(wacc_o), .lat_a_o(lat_a_o));
